/* File: include/irq_ctrl_pkg.sv */
// Constants and carriers shared by the two-level interrupt controller.
// Assumes an 8-bit special function register port driven by the core.
package irq_ctrl_pkg;

  // ==========================================================================
  // Register addresses and reset values.
  // ==========================================================================
  localparam logic [7:0] ADDR_ENABLE_PRIMARY = 8'ha8;   // source_enable_primary.
  localparam logic [7:0] ADDR_ENABLE_SECONDARY = 8'ha9; // source_enable_secondary.
  localparam logic [7:0] ADDR_LEVEL_SELECT = 8'hb8;     // level_select.
  localparam logic [7:0] RESET_BYTE = 8'h00;            // Power-on value of all three.
  localparam logic [7:0] SECONDARY_WMASK = 8'h03;       // Bits 7..2 are reserved, read zero.

  // ==========================================================================
  // Bit positions in the primary enable register.
  // ==========================================================================
  localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
  localparam int CONVERTER_IRQ_ENABLE_BIT = 6;
  localparam int TIMER2_IRQ_ENABLE_BIT = 5;
  localparam int UART_IRQ_ENABLE_BIT = 4;
  localparam int TIMER1_IRQ_ENABLE_BIT = 3;
  localparam int EXT1_IRQ_ENABLE_BIT = 2;
  localparam int TIMER0_IRQ_ENABLE_BIT = 1;
  localparam int EXT0_IRQ_ENABLE_BIT = 0;

  // Bit positions in the secondary enable register.
  localparam int SUPPLY_MONITOR_IRQ_ENABLE_BIT = 1;
  localparam int TWOWIRE_SPI_IRQ_ENABLE_BIT = 0;

  // Bit positions in the level select register.
  localparam int TWOWIRE_SPI_LEVEL_BIT = 7;
  localparam int CONVERTER_LEVEL_BIT = 6;
  localparam int TIMER2_LEVEL_BIT = 5;
  localparam int UART_LEVEL_BIT = 4;
  localparam int TIMER1_LEVEL_BIT = 3;
  localparam int EXT1_LEVEL_BIT = 2;
  localparam int TIMER0_LEVEL_BIT = 1;
  localparam int EXT0_LEVEL_BIT = 0;

  // ==========================================================================
  // Polling order, first (index 0) to last, and vectors.
  // ==========================================================================
  localparam int NUM_SOURCES = 9;
  localparam int POLL_SUPPLY = 0;
  localparam int POLL_EXT0 = 1;
  localparam int POLL_CONVERTER = 2;
  localparam int POLL_TIMER0 = 3;
  localparam int POLL_EXT1 = 4;
  localparam int POLL_TIMER1 = 5;
  localparam int POLL_TWOWIRE_SPI = 6;
  localparam int POLL_UART = 7;
  localparam int POLL_TIMER2 = 8;

  // Vector per poll index; entry 0 is the lowest slice.
  localparam logic [NUM_SOURCES*16-1:0] VECTOR_TABLE = {
    16'h002b, 16'h0023, 16'h003b, 16'h001b, 16'h0013,
    16'h000b, 16'h0033, 16'h0003, 16'h0043};

  // The supply monitor has no level bit; it is served at this level.
  localparam logic SUPPLY_MONITOR_LEVEL = 1'b0;

  // Level indices of the in-service mark.
  localparam int LVL_LOW = 0;
  localparam int LVL_HIGH = 1;

  // ==========================================================================
  // Carriers.
  // ==========================================================================
  // Raw source flags as raised by the peripherals.
  typedef struct packed {
    logic supply_monitor_flag;
    logic ext0_request_flag;
    logic ext1_request_flag;
    logic converter_done_flag;
    logic timer0_overflow_flag;
    logic timer1_overflow_flag;
    logic timer2_overflow_flag;
    logic timer2_external_flag;
    logic twowire_event_flag;
    logic spi_event_flag;
    logic uart_rx_done_flag;
    logic uart_tx_done_flag;
  } source_flags_s;

  // Whole controller state.
  typedef struct packed {
    logic [7:0] enable_primary;
    logic [7:0] enable_secondary;
    logic [7:0] level_select;
    logic [1:0] in_service;   // Bit 1 high level, bit 0 low level.
    logic req;                // Request to the core is standing.
    logic req_level;          // Level of the standing request.
    logic [15:0] vector;      // Vector of the standing request.
    logic [7:0] rdata;        // Register read answer.
  } ctrl_state_s;

endpackage

/* File: rtl/irq_ctrl.sv */
// Two-level interrupt controller with three special function registers.
// Assumes the core pulses ack when it pushes the program counter and jumps,
// and pulses ret when it returns from a service routine.
module irq_ctrl (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Special function register port.
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // Source flags.
  input wire irq_ctrl_pkg::source_flags_s flags_i,
  // Core handshake.
  input wire logic irq_ack_i,
  input wire logic irq_ret_i,
  output logic irq_req_o,
  output logic [15:0] irq_vector_o,
  output logic [1:0] in_service_o
);

  // ==========================================================================
  // State.
  // ==========================================================================
  irq_ctrl_pkg::ctrl_state_s st_reg;  // Registered state.
  irq_ctrl_pkg::ctrl_state_s st_next; // Next state.

  logic [irq_ctrl_pkg::NUM_SOURCES-1:0] src_flag;  // Flags in polling order.
  logic [irq_ctrl_pkg::NUM_SOURCES-1:0] src_en;    // Individual enables.
  logic [irq_ctrl_pkg::NUM_SOURCES-1:0] src_lvl;   // Level per source.
  logic [irq_ctrl_pkg::NUM_SOURCES-1:0] hi_req;    // Enabled high requests.
  logic [irq_ctrl_pkg::NUM_SOURCES-1:0] lo_req;    // Enabled low requests.
  logic hi_valid;      // Some high request waits.
  logic lo_valid;      // Some low request waits.
  logic [3:0] hi_idx;  // Winning high source.
  logic [3:0] lo_idx;  // Winning low source.
  logic global_en;     // Global enable.

  // ==========================================================================
  // Source gathering.
  // ==========================================================================
  // Shared-vector sources are the OR of their flags.
  assign src_flag = {
    flags_i.timer2_overflow_flag | flags_i.timer2_external_flag,
    flags_i.uart_rx_done_flag | flags_i.uart_tx_done_flag,
    flags_i.twowire_event_flag | flags_i.spi_event_flag,
    flags_i.timer1_overflow_flag,
    flags_i.ext1_request_flag,
    flags_i.timer0_overflow_flag,
    flags_i.converter_done_flag,
    flags_i.ext0_request_flag,
    flags_i.supply_monitor_flag};

  // Enables sorted into polling order.
  assign src_en = {
    st_reg.enable_primary[irq_ctrl_pkg::TIMER2_IRQ_ENABLE_BIT],
    st_reg.enable_primary[irq_ctrl_pkg::UART_IRQ_ENABLE_BIT],
    st_reg.enable_secondary[irq_ctrl_pkg::TWOWIRE_SPI_IRQ_ENABLE_BIT],
    st_reg.enable_primary[irq_ctrl_pkg::TIMER1_IRQ_ENABLE_BIT],
    st_reg.enable_primary[irq_ctrl_pkg::EXT1_IRQ_ENABLE_BIT],
    st_reg.enable_primary[irq_ctrl_pkg::TIMER0_IRQ_ENABLE_BIT],
    st_reg.enable_primary[irq_ctrl_pkg::CONVERTER_IRQ_ENABLE_BIT],
    st_reg.enable_primary[irq_ctrl_pkg::EXT0_IRQ_ENABLE_BIT],
    st_reg.enable_secondary[irq_ctrl_pkg::SUPPLY_MONITOR_IRQ_ENABLE_BIT]};

  // Levels sorted into polling order.
  assign src_lvl = {
    st_reg.level_select[irq_ctrl_pkg::TIMER2_LEVEL_BIT],
    st_reg.level_select[irq_ctrl_pkg::UART_LEVEL_BIT],
    st_reg.level_select[irq_ctrl_pkg::TWOWIRE_SPI_LEVEL_BIT],
    st_reg.level_select[irq_ctrl_pkg::TIMER1_LEVEL_BIT],
    st_reg.level_select[irq_ctrl_pkg::EXT1_LEVEL_BIT],
    st_reg.level_select[irq_ctrl_pkg::TIMER0_LEVEL_BIT],
    st_reg.level_select[irq_ctrl_pkg::CONVERTER_LEVEL_BIT],
    st_reg.level_select[irq_ctrl_pkg::EXT0_LEVEL_BIT],
    irq_ctrl_pkg::SUPPLY_MONITOR_LEVEL};

  assign global_en = st_reg.enable_primary[irq_ctrl_pkg::GLOBAL_IRQ_ENABLE_BIT];

  // Per-source gating: flag, own enable and global enable all needed.
  genvar g;
  generate
    for (g = 0; g < irq_ctrl_pkg::NUM_SOURCES; g++) begin : gen_src
      assign hi_req[g] = src_flag[g] & src_en[g] & global_en & src_lvl[g];
      assign lo_req[g] = src_flag[g] & src_en[g] & global_en & ~src_lvl[g];
    end
  endgenerate

  // ==========================================================================
  // Polling within each level.
  // ==========================================================================
  irq_poll_select #(.N(irq_ctrl_pkg::NUM_SOURCES), .IDX_W(4)) u_poll_hi (
    .req_i(hi_req),
    .valid_o(hi_valid),
    .idx_o(hi_idx)
  );

  irq_poll_select #(.N(irq_ctrl_pkg::NUM_SOURCES), .IDX_W(4)) u_poll_lo (
    .req_i(lo_req),
    .valid_o(lo_valid),
    .idx_o(lo_idx)
  );

  // ==========================================================================
  // Next-state logic.
  // ==========================================================================
  // A request is recomputed every cycle so that a newly arrived high request
  // replaces a waiting low one before the core takes it.
  always_comb begin
    st_next = st_reg;
    // Register writes; reserved secondary bits stay zero.
    if (sfr_wr_i) begin
      if (sfr_addr_i == irq_ctrl_pkg::ADDR_ENABLE_PRIMARY) begin
        st_next.enable_primary = sfr_wdata_i;
      end else if (sfr_addr_i == irq_ctrl_pkg::ADDR_ENABLE_SECONDARY) begin
        st_next.enable_secondary = sfr_wdata_i & irq_ctrl_pkg::SECONDARY_WMASK;
      end else if (sfr_addr_i == irq_ctrl_pkg::ADDR_LEVEL_SELECT) begin
        st_next.level_select = sfr_wdata_i;
      end
    end
    // Register reads answer one cycle later; unmapped reads give zero.
    st_next.rdata = irq_ctrl_pkg::RESET_BYTE;
    if (sfr_rd_i) begin
      if (sfr_addr_i == irq_ctrl_pkg::ADDR_ENABLE_PRIMARY) begin
        st_next.rdata = st_reg.enable_primary;
      end else if (sfr_addr_i == irq_ctrl_pkg::ADDR_ENABLE_SECONDARY) begin
        st_next.rdata = st_reg.enable_secondary;
      end else if (sfr_addr_i == irq_ctrl_pkg::ADDR_LEVEL_SELECT) begin
        st_next.rdata = st_reg.level_select;
      end
    end
    // Return clears the innermost routine, which is the high one if active.
    if (irq_ret_i) begin
      if (st_reg.in_service[irq_ctrl_pkg::LVL_HIGH]) begin
        st_next.in_service[irq_ctrl_pkg::LVL_HIGH] = 1'b0;
      end else begin
        st_next.in_service[irq_ctrl_pkg::LVL_LOW] = 1'b0;
      end
    end
    // Acceptance marks the level in service after the clear, so it wins.
    if (irq_ack_i && st_reg.req) begin
      st_next.in_service[st_reg.req_level] = 1'b1;
      st_next.req = 1'b0;
    end else if (hi_valid && !st_reg.in_service[irq_ctrl_pkg::LVL_HIGH]) begin
      st_next.req = 1'b1;
      st_next.req_level = 1'b1;
      st_next.vector = irq_ctrl_pkg::VECTOR_TABLE[hi_idx*16 +: 16];
    end else if (lo_valid && st_reg.in_service == 2'h0) begin
      st_next.req = 1'b1;
      st_next.req_level = 1'b0;
      st_next.vector = irq_ctrl_pkg::VECTOR_TABLE[lo_idx*16 +: 16];
    end else begin
      st_next.req = 1'b0;
    end
    if (srst_i) begin
      st_next = '0;
    end
  end

  // State register.
  always_ff @(posedge sys_clk_i) begin
    st_reg <= st_next;
  end

  assign sfr_rdata_o = st_reg.rdata;
  assign irq_req_o = st_reg.req;
  assign irq_vector_o = st_reg.vector;
  assign in_service_o = st_reg.in_service;

  // ==========================================================================
  // Assertions.
  // ==========================================================================
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  // Global enable is low in the registered state.
  sequence s_global_off;
    !global_en;
  endsequence

  // The core takes a standing high-level request at this edge.
  sequence s_accept_high;
    irq_ack_i && st_reg.req && st_reg.req_level;
  endsequence

  // The supply monitor waits at low level, no high request is pending,
  // nothing is in service and no acceptance happens now. The supply monitor
  // has no level bit of its own, so this is the only level at which its
  // place at the head of the poll can be seen.
  sequence s_supply_waits;
    lo_req[irq_ctrl_pkg::POLL_SUPPLY] && !hi_valid && st_reg.in_service == 2'h0
      && !(irq_ack_i && st_reg.req);
  endsequence

  a_global_blocks: assert property (s_global_off |=> !irq_req_o)
    else $error("Request raised while global enable was off.");
  a_same_level: assert property (
    irq_req_o && $past(st_reg.in_service[1]) |-> !st_reg.req_level)
    else $error("High request raised while high routine in service.");
  a_low_blocked: assert property (
    irq_req_o && !st_reg.req_level |-> $past(st_reg.in_service) == 2'h0)
    else $error("Low request raised during a routine.");
  a_high_first: assert property (
    irq_req_o && !st_reg.req_level |-> !$past(hi_valid))
    else $error("Low request chosen over waiting high one.");
  a_preempt: assert property (
    s_accept_high |=> st_reg.in_service[1] && !irq_req_o)
    else $error("High acceptance not marked in service.");
  a_ret_clears: assert property (
    irq_ret_i && st_reg.in_service[1] && !irq_ack_i |=> !st_reg.in_service[1])
    else $error("Return did not clear the high routine.");
  a_vector_first: assert property (
    s_supply_waits |=> irq_vector_o == 16'h0043)
    else $error("Supply monitor not first in low poll.");
  a_read_primary: assert property (
    sfr_rd_i && sfr_addr_i == irq_ctrl_pkg::ADDR_ENABLE_PRIMARY
      |=> sfr_rdata_o == $past(st_reg.enable_primary))
    else $error("Primary enable readback wrong.");

endmodule

/* File: rtl/irq_poll_select.sv */
// Fixed-order poll: picks the lowest-index set request.
// Assumes requests are already enabled and sorted into polling order.
module irq_poll_select #(
  parameter int N = 9,
  parameter int IDX_W = 4
) (
  // Requests in polling order.
  input wire logic [N-1:0] req_i,
  // Winner.
  output logic valid_o,
  output logic [IDX_W-1:0] idx_o
);

  // ==========================================================================
  // Priority scan.
  // ==========================================================================
  // Scan from last to first so that the first set entry is written last.
  always_comb begin
    valid_o = |req_i;
    idx_o = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        idx_o = IDX_W'(i);
      end
    end
  end

endmodule

/* File: tb/core_model.sv */
// Core model: takes requests, pushes the program counter, jumps to the vector.
// Assumes the controller's request and vector are registered on sys_clk_i.
module core_model (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // Controls from the bench.
  input wire logic accept_i,
  input wire logic [3:0] lag_i,
  input wire logic ret_cmd_i,
  // Controller side.
  input wire logic irq_req_i,
  input wire logic [15:0] irq_vector_i,
  output logic irq_ack_o,
  output logic irq_ret_o,
  output logic [15:0] pc_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] stack_q[$]; // Pushed return addresses.
  logic [3:0] wait_reg; // Cycles the request has stood unanswered.
  // The return pulse follows the bench's command directly.
  assign irq_ret_o = ret_cmd_i;
  // ==========================================================================
  // A slow core lets the request stand lag_i cycles, then raises acknowledge
  // for one cycle. It jumps at the edge where the controller takes that
  // acknowledge unless a return pops the stack at that edge, so it then loads
  // the vector that the controller marks in service, even when a high request
  // replaced a low one in the acknowledge cycle.
  always @(posedge sys_clk_i) begin
    irq_ack_o <= 1'b0;
    if (srst_i) begin
      pc_o <= 16'h1000;
      wait_reg <= 4'h0;
      stack_q.delete();
    end else if (irq_ret_o && stack_q.size() > 0) begin
      pc_o <= stack_q.pop_back();
    end else if (irq_ack_o) begin
      // A request that dropped meanwhile is not taken by the controller.
      if (irq_req_i) begin
        stack_q.push_back(pc_o);
        pc_o <= irq_vector_i;
      end
    end else if (accept_i && irq_req_i) begin
      if (wait_reg >= lag_i) begin
        irq_ack_o <= 1'b1;
        wait_reg <= 4'h0;
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end
  end
endmodule

/* File: tb/irq_ctrl_bench.sv */
// Self-checking bench of the interrupt controller with a core model.
// Assumes inputs change at the falling edge and the core model answers.
module irq_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0, srst_i = 1'b1, wr = 1'b0, rd = 1'b0, ack, ret, req;
  logic accept = 1'b0, ret_cmd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
  logic [15:0] vec, pc;
  logic [1:0] svc;
  logic [3:0] lag = 4'h0;
  irq_ctrl_pkg::source_flags_s flags = '0;
  int seed = 4800, mismatches = 0, compares = 0, lv, i, j;
  irq_ctrl u_irq_ctrl (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .sfr_addr_i(addr),
    .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
    .flags_i(flags), .irq_ack_i(ack), .irq_ret_i(ret), .irq_req_o(req),
    .irq_vector_o(vec), .in_service_o(svc));
  core_model u_core_model (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .accept_i(accept),
    .lag_i(lag), .ret_cmd_i(ret_cmd), .irq_req_i(req), .irq_vector_i(vec),
    .irq_ack_o(ack), .irq_ret_o(ret), .pc_o(pc));
  always #4 sys_clk_i = ~sys_clk_i;
  // ==========================================================================
  // Comparison, verdict and bus tasks.
  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(negedge sys_clk_i);
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(negedge sys_clk_i);
    wr = 1'b0;
  endtask
  // Read data stands only in the cycle after the read edge.
  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sys_clk_i);
    addr = a;
    rd = 1'b1;
    @(negedge sys_clk_i);
    rd = 1'b0;
    check({8'h00, rdata}, {8'h00, exp});
  endtask
  // Bounded wait on the request (which 0) or the in-service marks (which 1).
  task wait_for(input int which, input logic [1:0] e);
    for (int n = 0; n < 40 && (which ? svc : {1'b0, req}) !== e; n++) @(negedge sys_clk_i);
    check({14'h0, which ? svc : {1'b0, req}}, {14'h0, e});
    if ((which ? svc : {1'b0, req}) !== e) conclude();
  endtask
  task ret_pulse;
    @(negedge sys_clk_i);
    ret_cmd = 1'b1;
    @(negedge sys_clk_i);
    ret_cmd = 1'b0;
  endtask
  // Flag of poll index k; alt picks the second flag of a shared source.
  function automatic irq_ctrl_pkg::source_flags_s flag_of(int k, logic alt);
    flag_of = '0;
    case (k)
      0: flag_of.supply_monitor_flag = 1'b1;
      1: flag_of.ext0_request_flag = 1'b1;
      2: flag_of.converter_done_flag = 1'b1;
      3: flag_of.timer0_overflow_flag = 1'b1;
      4: flag_of.ext1_request_flag = 1'b1;
      5: flag_of.timer1_overflow_flag = 1'b1;
      6: if (alt) flag_of.spi_event_flag = 1'b1; else flag_of.twowire_event_flag = 1'b1;
      7: if (alt) flag_of.uart_tx_done_flag = 1'b1; else flag_of.uart_rx_done_flag = 1'b1;
      default: if (alt) flag_of.timer2_external_flag = 1'b1;
        else flag_of.timer2_overflow_flag = 1'b1;
    endcase
  endfunction
  function automatic logic [15:0] vec_of(int k);
    logic [15:0] t[9] = '{16'h0043, 16'h0003, 16'h0033, 16'h000b, 16'h0013,
                          16'h001b, 16'h003b, 16'h0023, 16'h002b};
    return t[k];
  endfunction
  // ==========================================================================
  // Main sequence.
  initial begin
    repeat (16) @(negedge sys_clk_i);
    srst_i = 1'b0;
    rd_chk(8'ha8, 8'h00);
    rd_chk(8'ha9, 8'h00);
    rd_chk(8'hb8, 8'h00);
    wr_reg(8'ha9, 8'hff);
    rd_chk(8'ha9, 8'h03);
    rd_chk(8'h55, 8'h00);
    for (i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      wr_reg(i[0] ? 8'hb8 : 8'ha8, d);
      rd_chk(i[0] ? 8'hb8 : 8'ha8, d);
    end
    // Global enable low blocks every enabled, flagged source.
    wr_reg(8'ha8, 8'h7f);
    for (j = 0; j < 9; j++) flags = flags | flag_of(j, 1'b0);
    repeat (5) @(negedge sys_clk_i);
    check({15'h0, req}, 16'h0);
    wr_reg(8'ha8, 8'hff);
    wait_for(0, 2'b01);
    flags = '0;
    wait_for(0, 2'b00);
    // Polling order at both levels, walking the top source down the table.
    for (lv = 0; lv < 2; lv++) begin
      wr_reg(8'hb8, lv ? 8'hff : 8'h00);
      for (i = lv; i < 9; i++) begin
        for (j = i; j < 9; j++) flags = flags | flag_of(j, 1'($random(seed)));
        accept = 1'b0;
        wait_for(0, 2'b01);
        check(vec, vec_of(i));
        lag = 4'($random(seed));
        accept = 1'b1;
        wait_for(1, (lv && i) ? 2'b10 : 2'b01);
        check(pc, vec_of(i));
        check({15'h0, req}, 16'h0);
        flags = '0;
        ret_pulse();
        wait_for(1, 2'b00);
      end
    end
    // Simultaneous levels: the high Timer 2 beats the supply monitor.
    wr_reg(8'hb8, 8'h20);
    accept = 1'b0;
    flags = flag_of(0, 1'b0) | flag_of(8, 1'b0);
    wait_for(0, 2'b01);
    check(vec, 16'h002b);
    accept = 1'b1;
    wait_for(1, 2'b10);
    flags = flag_of(0, 1'b0);
    ret_pulse();
    wait_for(1, 2'b01);
    check(pc, 16'h0043);
    // Low routine running; a low request waits, a high one preempts.
    flags = flag_of(4, 1'b0);
    wr_reg(8'hb8, 8'h01);
    repeat (5) @(negedge sys_clk_i);
    check({15'h0, req}, 16'h0);
    flags = flags | flag_of(1, 1'b0);
    wait_for(1, 2'b11);
    check(pc, 16'h0003);
    wr_reg(8'hb8, 8'h05);
    repeat (5) @(negedge sys_clk_i);
    check({15'h0, req}, 16'h0);
    flags = flag_of(4, 1'b0);
    accept = 1'b0;
    ret_pulse();
    wait_for(1, 2'b01);
    wait_for(0, 2'b01);
    check(vec, 16'h0013);
    accept = 1'b1;
    wait_for(1, 2'b11);
    check(pc, 16'h0013);
    flags = '0;
    ret_pulse();
    ret_pulse();
    wait_for(1, 2'b00);
    // Individual enables: global enable alone lets no flagged source through.
    accept = 1'b0;
    wr_reg(8'ha8, 8'h80);
    wr_reg(8'ha9, 8'h00);
    for (j = 0; j < 9; j++) flags = flags | flag_of(j, 1'b1);
    repeat (5) @(negedge sys_clk_i);
    check({15'h0, req}, 16'h0);
    wr_reg(8'ha9, 8'h01);
    wait_for(0, 2'b01);
    check(vec, 16'h003b);
    flags = '0;
    wait_for(0, 2'b00);
    conclude();
  end
endmodule
